// ==== burst_sram_pkg.sv ====
package burst_sram_pkg;

    localparam int LANES       = 4;
    localparam int LANE_W      = 8;
    localparam int DATA_W      = LANES * LANE_W;
    localparam int COUNT_W     = 2;
    localparam int FIFO_DEPTH  = 4;
    localparam int ADDR_W_DEF  = 6;

    localparam logic [COUNT_W-1:0] COUNT_RST = 2'h0;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 2'h1;
    localparam logic [COUNT_W-1:0] COUNT_END = 2'h3;

    localparam logic DRIVE_RST   = 1'b0;
    localparam logic ORDER_RST   = 1'b1;

    typedef enum {st_deselected, st_burst_read, st_burst_write} burst_state_t;
    typedef enum {op_none, op_read, op_write} op_t;

endpackage : burst_sram_pkg

// ==== sync_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none

module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clock,     // system clock
    input  wire logic             rst,       // async reset, active high
    input  wire logic             in_valid,  // push request
    output logic                  in_ready,  // room for one word
    input  wire logic [WIDTH-1:0] in_data,   // pushed word
    output logic                  out_valid, // head word present
    input  wire logic             out_ready, // drain accepts head
    output logic [WIDTH-1:0]      out_data   // head word
);
    localparam int IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] store_r [DEPTH];
    logic [IDX_W-1:0] wr_idx_r;
    logic [IDX_W-1:0] rd_idx_r;
    logic [CNT_W-1:0] count_r;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (count_r != CNT_W'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data  = store_r[rd_idx_r];

    function automatic logic [IDX_W-1:0] wrap_inc(input logic [IDX_W-1:0] idx);
        wrap_inc = (idx == IDX_W'(DEPTH - 1)) ? '0 : idx + IDX_W'(1);
    endfunction : wrap_inc

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_idx_r <= '0;
            rd_idx_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) wr_idx_r <= wrap_inc(wr_idx_r);
            if (pop)  rd_idx_r <= wrap_inc(rd_idx_r);
            if (push && !pop) count_r <= count_r + CNT_W'(1);
            else if (pop && !push) count_r <= count_r - CNT_W'(1);
        end
    end

    // storage has no reset: contents are don't-care until written
    always_ff @(posedge clock) begin
        if (push) store_r[wr_idx_r] <= in_data;
    end

endmodule : sync_fifo

`default_nettype wire

// ==== burst_sram_port.sv ====
// Notes on behaviour
// [RL1] inputs captured in registers at clock rise; read data launched from output register
// [RL2] clock qualifier high: edge ignored, all state held; here the commit fifo still drains queued writes into memory
// [RL3] read begins: qualified, all selects active, write strobe high, advance/load low
// [RL4] started read data appears after the next qualified edge, output enable low
// [RL5] host holds output enable low for read data; drivers follow it
// [RL6] next operation may issue while read data returns, no idle cycles
// [RL7] deselect at an edge tri-states outputs after the following edge
// [RL8] after deselect host loads a fresh address with advance/load low
// [RL9] burst counter serves up to four accesses from one address
// [RL10] order strap: low linear, high interleaved; static while operating
// [RL11] counter acts on two low address bits, wraps; linear adds count
// [RL12] advance/load high at qualified edge steps counter regardless of selects
// [RL13] direction captured at burst start and kept for the burst
// [RL14] write begins: qualified, all selects active, write strobe low
// [RL15] edge after write start tri-states data and parity, next address taken
// [RL16] write data captured at second edge after write start, self-timed
// [RL17] only selected byte lanes and their parity bits are written
// [RL18] host never drives data lines while device drives them
// [RL19] burst write beats ignore selects and strobe, step the counter
// [RL20] host drives matching byte-lane selects on every burst write beat
// [RL21] sleep input enters or leaves low-power state in two cycles, data kept
// [RL22] host deselects before sleep, keeps selects inactive during recovery
// [RL23] interleaved order is loaded value xor the count
// [RL24] outputs tri-stated in first clock after leaving deselect
// [RL25] after power-up deselected with data and parity tri-stated
// [RL26] during ignored edges output register keeps last launched word
`timescale 1ns/1ps
`default_nettype none

module burst_sram_port
    import burst_sram_pkg::*;
#(
    parameter int ADDR_W = burst_sram_pkg::ADDR_W_DEF
) (
    input  wire logic                         clock,              // 25 MHz system clock
    input  wire logic                         rst,                // async reset, active high
    input  wire logic                         clock_qualifier_n,  // low: edge recognised
    input  wire logic                         select_one_n,       // chip select, active low
    input  wire logic                         select_two,         // chip select, active high
    input  wire logic                         select_three_n,     // chip select, active low
    input  wire logic                         advance_or_load,    // high advance, low load
    input  wire logic                         write_enable_n,     // low write, high read
    input  wire logic [burst_sram_pkg::LANES-1:0] byte_lane_select_n, // per-lane write, low
    input  wire logic [ADDR_W-1:0]            address,            // word address
    input  wire logic                         output_enable_n,    // async output enable, low
    input  wire logic                         burst_order,        // strap: 1 interleaved
    input  wire logic                         sleep_request,      // async sleep, high
    input  wire logic [burst_sram_pkg::DATA_W-1:0] data_in,       // data pins, input side
    output logic [burst_sram_pkg::DATA_W-1:0] data_out,           // data pins, output side
    output logic                              data_oe_n,          // low while driving data
    input  wire logic [burst_sram_pkg::LANES-1:0] parity_lines_in,  // parity input side
    output logic [burst_sram_pkg::LANES-1:0]  parity_lines_out,   // parity output side
    output logic                              parity_oe_n         // low while driving parity
);
    import burst_sram_pkg::*;

    localparam int WORDS  = 2 ** ADDR_W;
    localparam int LANE_T = LANE_W + 1;
    localparam int ENTRY  = ADDR_W + LANES + LANES * LANE_T;

    // sleep synchroniser and strap capture
    logic sleep_meta_r;
    logic asleep_r;
    logic order_r;
    logic order_taken_r;

    // burst tracking
    burst_state_t        state_r;
    logic [ADDR_W-1:0]   base_r;
    logic [COUNT_W-1:0]  count_r;

    // issue and write-capture pipeline
    op_t                 issue_r;
    logic [ADDR_W-1:0]   issue_addr_r;
    logic [LANES-1:0]    issue_lanes_r;
    logic                cap_valid_r;
    logic [ADDR_W-1:0]   cap_addr_r;
    logic [LANES-1:0]    cap_lanes_r;

    // output register
    logic                drive_r;
    logic [DATA_W-1:0]   dout_r;
    logic [LANES-1:0]    pout_r;

    // commit fifo
    logic                fifo_in_ready;
    logic                fifo_out_valid;
    logic [ENTRY-1:0]    fifo_out_data;
    logic [ENTRY-1:0]    fifo_in_data;

    function automatic logic [COUNT_W-1:0] burst_bits(input logic [COUNT_W-1:0] base,
                                                      input logic [COUNT_W-1:0] cnt,
                                                      input logic               inter);
        burst_bits = inter ? (base ^ cnt) : COUNT_W'(base + cnt);  // RL11 RL23
    endfunction : burst_bits

    wire selected  = !select_one_n && select_two && !select_three_n;
    // a full commit fifo stalls the edge like the qualifier does
    wire q_edge    = !clock_qualifier_n && fifo_in_ready && !asleep_r;
    wire load_op   = !advance_or_load && selected;
    wire in_burst  = (state_r != st_deselected);

    wire [COUNT_W-1:0] next_count = COUNT_W'(count_r + COUNT_ONE);
    wire [COUNT_W-1:0] cur_low    = burst_bits(base_r[COUNT_W-1:0], count_r, order_r);
    wire [COUNT_W-1:0] step_low   = burst_bits(base_r[COUNT_W-1:0], next_count, order_r);
    wire [ADDR_W-1:0]  step_addr  = {base_r[ADDR_W-1:COUNT_W], step_low};

    // enum is two-state, so it is a variable under a continuous assignment
    op_t               next_op;
    assign next_op = !advance_or_load ? (!selected ? op_none :
                     (write_enable_n ? op_read : op_write)) :
                     (state_r == st_burst_read)  ? op_read  :
                     (state_r == st_burst_write) ? op_write : op_none;
    wire [ADDR_W-1:0]  next_addr  = !advance_or_load ? address : step_addr;

    wire               push       = cap_valid_r && q_edge;
    wire               drain      = fifo_out_valid && !asleep_r;

    assign fifo_in_data = {cap_addr_r, cap_lanes_r, parity_lines_in, data_in};

    // output enable is asynchronous, so it gates the registered drive directly
    assign data_oe_n        = !drive_r || output_enable_n;  // RL5
    assign parity_oe_n      = !drive_r || output_enable_n;
    assign data_out         = dout_r;
    assign parity_lines_out = pout_r;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sleep_meta_r <= 1'b0;
            asleep_r     <= 1'b0;
        end else begin
            sleep_meta_r <= sleep_request;
            asleep_r     <= sleep_meta_r;  // RL21
        end
    end

    // strap taken once after release, never followed afterwards
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            order_r       <= ORDER_RST;
            order_taken_r <= 1'b0;
        end else if (!order_taken_r) begin
            order_r       <= burst_order;  // RL10
            order_taken_r <= 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r <= st_deselected;  // RL25
            base_r  <= '0;
            count_r <= COUNT_RST;
        end else if (asleep_r) begin
            state_r <= st_deselected;  // RL22
        end else if (q_edge) begin  // RL2
            if (!advance_or_load) begin
                if (selected) begin
                    // direction latched only here
                    state_r <= write_enable_n ? st_burst_read : st_burst_write;  // RL3 RL13 RL14
                    base_r  <= address;  // RL1
                    count_r <= COUNT_RST;
                end else begin
                    state_r <= st_deselected;  // RL8
                end
            end else if (in_burst) begin
                count_r <= next_count;  // RL9 RL11 RL12 RL19
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            issue_r       <= op_none;
            issue_addr_r  <= '0;
            issue_lanes_r <= '0;
        end else if (asleep_r) begin
            issue_r       <= op_none;
        end else if (q_edge) begin
            issue_r       <= next_op;  // RL6
            issue_addr_r  <= next_addr;  // RL15
            issue_lanes_r <= ~byte_lane_select_n;  // RL20
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cap_valid_r <= 1'b0;
            cap_addr_r  <= '0;
            cap_lanes_r <= '0;
        end else if (asleep_r) begin
            cap_valid_r <= 1'b0;
        end else if (q_edge) begin
            cap_valid_r <= (issue_r == op_write);  // RL16
            cap_addr_r  <= issue_addr_r;
            cap_lanes_r <= issue_lanes_r;
        end
    end

    logic [LANE_T-1:0] read_lane [LANES];
    logic [DATA_W-1:0] read_data;
    logic [LANES-1:0]  read_par;

    genvar ln;
    generate
        for (ln = 0; ln < LANES; ln++) begin : g_lane
            logic [LANE_T-1:0] mem_r [WORDS];
            wire  [ADDR_W-1:0] w_addr  = fifo_out_data[ENTRY-1 -: ADDR_W];
            wire               w_sel   = fifo_out_data[LANES * LANE_T + ln];
            wire  [LANE_T-1:0] w_word  = {fifo_out_data[DATA_W + ln],
                                          fifo_out_data[ln*LANE_W +: LANE_W]};
            always_ff @(posedge clock) begin
                if (drain && w_sel) mem_r[w_addr] <= w_word;  // RL17
            end
            assign read_lane[ln] = mem_r[issue_addr_r];
            assign read_data[ln*LANE_W +: LANE_W] = read_lane[ln][LANE_W-1:0];
            assign read_par[ln] = read_lane[ln][LANE_W];
        end
    endgenerate

    // writes still queued are not forwarded to reads of the same word
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            drive_r <= DRIVE_RST;  // RL25
            dout_r  <= '0;
            pout_r  <= '0;
        end else if (asleep_r) begin
            drive_r <= 1'b0;
        end else if (q_edge) begin  // RL26
            drive_r <= (issue_r == op_read);  // RL4 RL7 RL15 RL24
            if (issue_r == op_read) begin
                dout_r <= read_data;  // RL1
                pout_r <= read_par;
            end
        end
    end

    sync_fifo #(
        .WIDTH (ENTRY),
        .DEPTH (FIFO_DEPTH)
    ) u_commit_fifo (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (!asleep_r),
        .out_data  (fifo_out_data)
    );

    stall_hold_a: assert property (@(posedge clock) disable iff (rst) // RL2 RL26
        clock_qualifier_n && !asleep_r |=> $stable(dout_r) && $stable(drive_r)
            && $stable(count_r) && $stable(issue_r))
        else $error("state moved on an ignored edge");

    read_start_a: assert property (@(posedge clock) disable iff (rst) // RL3
        q_edge && selected && !advance_or_load && write_enable_n
            |=> state_r == st_burst_read && issue_r == op_read && issue_addr_r == $past(address))
        else $error("read did not start");

    read_data_a: assert property (@(posedge clock) disable iff (rst) // RL4
        issue_r == op_read && q_edge |=> drive_r && dout_r == $past(read_data))
        else $error("read data not launched");

    deselect_a: assert property (@(posedge clock) disable iff (rst) // RL7
        q_edge && !advance_or_load && !selected ##1 q_edge |=> !drive_r)
        else $error("outputs not released after deselect");

    write_tristate_a: assert property (@(posedge clock) disable iff (rst) // RL15
        q_edge && load_op && !write_enable_n ##1 q_edge |=> !drive_r && cap_valid_r)
        else $error("outputs driven in write data phase");

    write_capture_a: assert property (@(posedge clock) disable iff (rst) // RL16
        q_edge && load_op && !write_enable_n ##1 q_edge ##1 q_edge
            |-> push && cap_addr_r == $past(address, 2))
        else $error("write data not captured on second edge");

    burst_step_a: assert property (@(posedge clock) disable iff (rst) // RL11
        q_edge && advance_or_load && in_burst |=> count_r == COUNT_W'($past(count_r) + 2'h1))
        else $error("burst counter did not step");

    burst_dir_a: assert property (@(posedge clock) disable iff (rst) // RL13
        q_edge && advance_or_load && state_r == st_burst_write |=> state_r == st_burst_write)
        else $error("burst direction changed");

    interleave_a: assert property (@(posedge clock) disable iff (rst) // RL23
        order_r && count_r == COUNT_END |-> cur_low == ~base_r[COUNT_W-1:0])
        else $error("interleaved order wrong");

    sleep_entry_a: assert property (@(posedge clock) disable iff (rst) // RL21
        sleep_request [*2] |=> asleep_r ##1 !drive_r)
        else $error("sleep not entered in two cycles");

endmodule : burst_sram_port

`default_nettype wire

// ==== host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module host_model
    import burst_sram_pkg::*;
#(
    parameter int ADDR_W = 6
) (
    input  wire logic                             clock,              // system clock
    output logic                                  clock_qualifier_n,  // edge qualifier
    output logic                                  select_one_n,       // select, low
    output logic                                  select_two,         // select, high
    output logic                                  select_three_n,     // select, low
    output logic                                  advance_or_load,    // high advance
    output logic                                  write_enable_n,     // low write
    output logic [burst_sram_pkg::LANES-1:0]      byte_lane_select_n, // lane writes
    output logic [ADDR_W-1:0]                     address,            // word address
    output logic                                  output_enable_n,    // output enable
    output logic                                  burst_order,        // order strap
    output logic                                  sleep_request,      // sleep input
    output logic [burst_sram_pkg::DATA_W-1:0]     data_in,            // write data
    output logic [burst_sram_pkg::LANES-1:0]      parity_lines_in     // write parity
);
    import burst_sram_pkg::*;
    localparam int DES = 0, RD = 1, WR = 2, ADV = 3, STALL = 4;
    logic [DATA_W+LANES-1:0] mem [2**ADDR_W];  // reference array, parity above data
    logic [DATA_W+LANES-1:0] exp_q [$];        // read words still owed by the device
    logic [ADDR_W-1:0]       base, pend_a, pend_a2, ea;
    logic [COUNT_W-1:0]      cnt = 2'h0;
    logic [LANES-1:0]        pend_ln, pend_ln2;
    logic                    wr_burst = 1'b0, active = 1'b0, pend_w = 1'b0, pend_w2 = 1'b0;

    initial begin
        clock_qualifier_n = 1'b0;
        {select_one_n, select_two, select_three_n} = 3'h6;
        advance_or_load = 1'b0;
        write_enable_n = 1'b1;
        byte_lane_select_n = 4'hf;
        address = '0;
        output_enable_n = 1'b0;
        burst_order = 1'b0;
        sleep_request = 1'b0;
        data_in = 32'h0;
        parity_lines_in = 4'h0;
    end

    // one bus cycle; write data is driven two qualified beats after its issue
    task automatic beat(input int kind, input logic [ADDR_W-1:0] a,
                        input logic [LANES-1:0] ln_n, input logic [63:0] r);
        int n;
        @(posedge clock);
        clock_qualifier_n <= (kind == STALL);
        if (kind == STALL) return;
        if (pend_w2) begin
            data_in <= r[31:0];
            parity_lines_in <= r[35:32];
            for (n = 0; n < LANES; n++) if (!pend_ln2[n]) begin
                mem[pend_a2][8*n+:8] = r[8*n+:8];
                mem[pend_a2][DATA_W+n] = r[DATA_W+n];
            end
        end else begin
            // released lines show a changing pattern, never the last value
            data_in <= ~data_in;
            parity_lines_in <= ~parity_lines_in;
        end
        pend_w2 = pend_w;
        pend_a2 = pend_a;
        pend_ln2 = pend_ln;
        pend_w = 1'b0;
        advance_or_load <= (kind == ADV);
        write_enable_n <= (kind != WR);
        byte_lane_select_n <= ln_n;
        address <= a;
        if (kind == RD || kind == WR)
            {select_one_n, select_two, select_three_n} <= 3'h2;
        else
            {select_one_n, select_two, select_three_n} <= (r[42:40] == 3'h2) ? 3'h6 : r[42:40];
        if (kind == RD || kind == WR) begin
            base = a;
            cnt = 2'h0;
            wr_burst = (kind == WR);
            active = 1'b1;
        end else if (kind == DES) active = 1'b0;
        else cnt = cnt + 2'h1;
        ea = {base[ADDR_W-1:2], burst_order ? base[1:0] ^ cnt : base[1:0] + cnt};
        if (active && wr_burst) begin
            pend_w = 1'b1;
            pend_a = ea;
            pend_ln = ln_n;
        end else if (active) exp_q.push_back(mem[ea]);
    endtask : beat
endmodule : host_model

`default_nettype wire

// ==== test_pipelined_burst_sram_port.sv ====
`timescale 1ns/1ps
`default_nettype none

module test_pipelined_burst_sram_port;
    import burst_sram_pkg::*;
    localparam int DES = 0, RD = 1, WR = 2, ADV = 3, STALL = 4;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic clock_qualifier_n, select_one_n, select_two, select_three_n, advance_or_load;
    logic write_enable_n, output_enable_n, burst_order, sleep_request, data_oe_n, parity_oe_n;
    logic [LANES-1:0]        byte_lane_select_n, parity_lines_in, parity_lines_out;
    logic [5:0]              address;
    logic [DATA_W-1:0]       data_in, data_out;
    logic [DATA_W+LANES-1:0] last_word, exp_word;
    logic [31:0]             seed = 32'hc735, lr;
    logic                    qual_prev = 1'b0;
    int num_errors = 0, check_count = 0, cycles = 0, i;

    always #20 clock = ~clock;

    burst_sram_port i_burst_sram_port (.clock, .rst, .clock_qualifier_n, .select_one_n,
        .select_two, .select_three_n, .advance_or_load, .write_enable_n, .byte_lane_select_n,
        .address, .output_enable_n, .burst_order, .sleep_request, .data_in, .data_out,
        .data_oe_n, .parity_lines_in, .parity_lines_out, .parity_oe_n);
    host_model i_host_model (.clock, .clock_qualifier_n, .select_one_n, .select_two,
        .select_three_n, .advance_or_load, .write_enable_n, .byte_lane_select_n, .address,
        .output_enable_n, .burst_order, .sleep_request, .data_in, .parity_lines_in);

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic check(input string what, input logic [DATA_W+LANES-1:0] exp,
                         input logic [DATA_W+LANES-1:0] got);
        check_count++;
        if (exp !== got) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    task automatic b(input int kind, input logic [5:0] a, input logic [LANES-1:0] ln_n);
        i_host_model.beat(kind, a, ln_n, {xs(), xs()});
    endtask : b

    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    // a drive seen after a qualified edge must answer the oldest owed read
    always @(posedge clock) qual_prev <= (clock_qualifier_n === 1'b0) && (rst === 1'b0);
    always @(negedge clock) begin
        check("parity enable", {35'h0, data_oe_n}, {35'h0, parity_oe_n});
        if (output_enable_n === 1'b1)
            check("output gate", 36'h1, {35'h0, data_oe_n});
        else if (data_oe_n === 1'b0 && !qual_prev)
            check("held word", last_word, {parity_lines_out, data_out});
        else if (data_oe_n === 1'b0 && i_host_model.exp_q.size() == 0)
            check("spare drive", 36'h1, {35'h0, data_oe_n});
        else if (data_oe_n === 1'b0) begin
            exp_word = i_host_model.exp_q.pop_front();
            last_word = {parity_lines_out, data_out};
            check("read word", exp_word, last_word);
        end
    end

    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        check("reset drive", 36'h1, {35'h0, data_oe_n});
        for (i = 0; i < 16; i += 4) begin
            b(WR, 6'(i), 4'h0);
            repeat (3) b(ADV, 6'h0, 4'h0);
        end
        repeat (4) b(DES, 6'h0, 4'h0);
        b(WR, 6'h5, 4'ha);
        for (i = 0; i < 3; i++) begin
            lr = xs();
            b(ADV, 6'h0, lr[3:0]);
        end
        repeat (4) b(DES, 6'h0, 4'h0);
        b(RD, 6'h5, 4'h0);
        repeat (3) b(ADV, 6'h0, 4'h0);
        b(RD, 6'h9, 4'h0);
        b(WR, 6'hc, 4'h0);
        b(RD, 6'hd, 4'h0);
        b(ADV, 6'h0, 4'h0);
        b(STALL, 6'h0, 4'h0);
        b(STALL, 6'h0, 4'h0);
        i_host_model.output_enable_n <= 1'b1;
        b(STALL, 6'h0, 4'h0);
        i_host_model.output_enable_n <= 1'b0;
        b(DES, 6'h0, 4'h0);
        repeat (2) b(ADV, 6'h0, 4'h0);
        repeat (3) b(DES, 6'h0, 4'h0);
        i_host_model.sleep_request <= 1'b1;
        repeat (5) b(DES, 6'h0, 4'h0);
        i_host_model.sleep_request <= 1'b0;
        repeat (5) b(DES, 6'h0, 4'h0);
        b(RD, 6'hc, 4'h0);
        repeat (3) b(ADV, 6'h0, 4'h0);
        repeat (3) b(DES, 6'h0, 4'h0);
        rst <= 1'b1;
        i_host_model.burst_order <= 1'b1;
        repeat (3) b(DES, 6'h0, 4'h0);
        rst <= 1'b0;
        b(RD, 6'h6, 4'h0);
        repeat (3) b(ADV, 6'h0, 4'h0);
        b(WR, 6'h1, 4'h0);
        repeat (3) b(ADV, 6'h0, 4'h3);
        repeat (4) b(DES, 6'h0, 4'h0);
        b(RD, 6'h3, 4'h0);
        repeat (3) b(ADV, 6'h0, 4'h0);
        repeat (4) b(DES, 6'h0, 4'h0);
        check("owed reads", 36'h0, 36'(i_host_model.exp_q.size()));
        tally_and_finish();
    end
endmodule : test_pipelined_burst_sram_port

`default_nettype wire
